// >>> strap_gpio_regs.svh
// Functional notes
// - Reset high forces all logic to defaults
// - Capture config-select straps at reset release
// - Config pins become general pins 0-2
// - Status shows live and latched pin bits
// - Test strap high at release enters test
// - Test pin becomes general pin 3
// - Mode 01 enables crystal driver
// - Mode 10 takes external clock on reference
// - Six-output parts drop outputs 2,5,7,10
// - Interface straps captured, then serial pins
`ifndef STRAP_GPIO_REGS_SVH
`define STRAP_GPIO_REGS_SVH
`define REF_MODE_CRYSTAL   2'h1
`define REF_MODE_EXTCLK    2'h2
`define REF_MODE_RESET     2'h0
`define OUTPUT_MASK_SIX    10'h1AD
`define OUTPUT_MASK_TEN    10'h3FF
`define PIN_CFG_INPUT      2'h0
`define PIN_CFG_OUT_LOW    2'h1
`define PIN_CFG_OUT_HIGH   2'h2
`define PIN_CFG_OUT_STATUS 2'h3
`define RESET_MIN_NS       1000
`define CLK_PERIOD_NS      40
`define RESET_MIN_CYCLES   ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> strap_gpio_pkg.sv
`default_nettype none
package strap_gpio_pkg;
  typedef enum logic [1:0] {
    HOLD,
    SETTLE,
    RUN
  } phase_type;
endpackage
`default_nettype wire

// >>> pin_sync.sv
`default_nettype none
module pin_sync (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [5:0] rawIn,
  output logic      [5:0] syncOut
);
  typedef struct packed {
    logic [5:0] stage1;
    logic [5:0] stage2;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  always_comb begin
    next_state        = state;
    next_state.stage1 = rawIn;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign syncOut = state.stage2;
endmodule
`default_nettype wire

// >>> reset_strap_and_gpio_mux.sv
`include "strap_gpio_regs.svh"
`default_nettype none
module reset_strap_and_gpio_mux
  import strap_gpio_pkg::*;
#(
  parameter bit SIX_OUTPUT = 1'b0
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [3:0] generalPinIn,
  output logic      [3:0] generalPinOut,
  output logic      [3:0] generalPinOe,
  input  wire logic [1:0] interfaceStrapIn,
  input  wire logic [7:0] pinControlRegOne,
  input  wire logic [1:0] pin2ConfigField,
  input  wire logic [1:0] pin3ConfigField,
  input  wire logic [1:0] referencePinMode,
  input  wire logic       statusLatchClear,
  input  wire logic [9:0] outputEnableReq,
  output logic      [2:0] configSelect,
  output logic            factoryTest,
  output logic      [1:0] interfaceMode,
  output logic            strapValid,
  output logic      [7:0] pinStatusReg,
  output logic            crystalDriverEn,
  output logic            externalClockEn,
  output logic      [9:0] outputClockEn
);
  typedef struct packed {
    phase_type  phase;
    logic [2:0] configSelect;
    logic       factoryTest;
    logic [1:0] interfaceMode;
    logic       strapValid;
    logic [3:0] pinOut;
    logic [3:0] pinOe;
    logic [3:0] latched;
    logic [3:0] live;
    logic       crystalEn;
    logic       extClkEn;
    logic [9:0] outEn;
  } mux_state_type;

  mux_state_type state;
  mux_state_type next_state;
  logic [5:0]    syncPins;
  logic [7:0]    pinCfg;

  // Straps arrive on pins, so both groups are synchronised first
  pin_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .rawIn    ({interfaceStrapIn, generalPinIn}),
    .syncOut  (syncPins)
  );

  // Pins 0,1 from control reg one; pin 2 and 3 from fields of reg two
  assign pinCfg = {pin3ConfigField, pin2ConfigField, pinControlRegOne[3:0]};

  always_comb begin
    next_state = state;
    case (state.phase)
      // First clock after release: sync chain still holds reset zeros
      HOLD: begin
        next_state.phase = SETTLE;
      end
      SETTLE: begin
        next_state.phase = RUN;
      end
      // Capture exactly once; sync has now seen pin levels at release
      RUN: begin
        if (!state.strapValid) begin
          next_state.configSelect  = syncPins[2:0];
          next_state.factoryTest   = syncPins[3];
          next_state.interfaceMode = syncPins[5:4];
          next_state.strapValid    = 1'b1;
        end
      end
      default: begin
        next_state.phase = HOLD;
      end
    endcase

    for (int i = 0; i < 4; i++) begin
      if (state.strapValid) begin
        case (pinCfg[2*i +: 2])
          `PIN_CFG_OUT_LOW: begin
            next_state.pinOut[i] = 1'b0;
            next_state.pinOe[i]  = 1'b1;
          end
          `PIN_CFG_OUT_HIGH: begin
            next_state.pinOut[i] = 1'b1;
            next_state.pinOe[i]  = 1'b1;
          end
          `PIN_CFG_OUT_STATUS: begin
            next_state.pinOut[i] = state.factoryTest;
            next_state.pinOe[i]  = 1'b1;
          end
          default: begin
            next_state.pinOut[i] = 1'b0;
            next_state.pinOe[i]  = 1'b0;
          end
        endcase
      end else begin
        // Pins stay inputs until straps are safely taken
        next_state.pinOut[i] = 1'b0;
        next_state.pinOe[i]  = 1'b0;
      end
    end

    next_state.live = syncPins[3:0];
    // Set wins over clear so a pin high during clear is kept
    if (statusLatchClear) begin
      next_state.latched = state.strapValid ? syncPins[3:0] : 4'h0;
    end else if (state.strapValid) begin
      next_state.latched = state.latched | syncPins[3:0];
    end

    next_state.crystalEn = (referencePinMode == `REF_MODE_CRYSTAL);
    next_state.extClkEn  = (referencePinMode == `REF_MODE_EXTCLK);
    next_state.outEn     = outputEnableReq &
                           (SIX_OUTPUT ? `OUTPUT_MASK_SIX : `OUTPUT_MASK_TEN);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state           <= '0;
      state.phase     <= HOLD;
    end else begin
      state <= next_state;
    end
  end

  assign configSelect    = state.configSelect;
  assign factoryTest     = state.factoryTest;
  assign interfaceMode   = state.interfaceMode;
  assign strapValid      = state.strapValid;
  assign generalPinOut   = state.pinOut;
  assign generalPinOe    = state.pinOe;
  assign pinStatusReg    = {state.latched, state.live};
  assign crystalDriverEn = state.crystalEn;
  assign externalClockEn = state.extClkEn;
  assign outputClockEn   = state.outEn;

  chk_strap_held: assert property (@(posedge core_clk) disable iff (rst)
    strapValid |=> $stable(configSelect) && $stable(factoryTest) && $stable(interfaceMode))
    else $error("Strap value changed after capture");

  chk_strap_once: assert property (@(posedge core_clk) disable iff (rst)
    $rose(strapValid) |-> configSelect == $past(syncPins[2:0]))
    else $error("Config select not taken from strap pins");

  chk_test_strap: assert property (@(posedge core_clk) disable iff (rst)
    $rose(strapValid) |-> factoryTest == $past(syncPins[3]))
    else $error("Test strap not captured");

  chk_iface_strap: assert property (@(posedge core_clk) disable iff (rst)
    $rose(strapValid) |-> interfaceMode == $past(syncPins[5:4]))
    else $error("Interface straps not captured");

  chk_crystal_mode: assert property (@(posedge core_clk) disable iff (rst)
    referencePinMode == `REF_MODE_CRYSTAL |=> crystalDriverEn && !externalClockEn)
    else $error("Crystal driver not enabled");

  chk_extclk_mode: assert property (@(posedge core_clk) disable iff (rst)
    referencePinMode == `REF_MODE_EXTCLK |=> externalClockEn && !crystalDriverEn)
    else $error("External clock not selected");

  chk_six_outputs: assert property (@(posedge core_clk) disable iff (rst)
    SIX_OUTPUT |-> !outputClockEn[1] && !outputClockEn[4] && !outputClockEn[6] &&
                   !outputClockEn[9])
    else $error("Absent output enabled");

  chk_pins_idle: assert property (@(posedge core_clk) disable iff (rst)
    !strapValid |-> generalPinOe == 4'h0)
    else $error("Pin driven before strap capture");

  chk_live_status: assert property (@(posedge core_clk) disable iff (rst)
    pinStatusReg[3:0] == $past(syncPins[3:0], 1))
    else $error("Live status wrong");

  chk_reset_defaults: assert property (@(posedge core_clk)
    rst |-> !strapValid && generalPinOe == 4'h0)
    else $error("Reset defaults not held");

  chk_pin3_drive: assert property (@(posedge core_clk) disable iff (rst)
    strapValid && pin3ConfigField == `PIN_CFG_OUT_HIGH |=> generalPinOe[3] && generalPinOut[3])
    else $error("Pin 3 not driven high");

  chk_pin0_input: assert property (@(posedge core_clk) disable iff (rst)
    strapValid && pinControlRegOne[1:0] == `PIN_CFG_INPUT |=> !generalPinOe[0])
    else $error("Pin 0 driven while set as input");

  chk_pin2_low: assert property (@(posedge core_clk) disable iff (rst)
    strapValid && pin2ConfigField == `PIN_CFG_OUT_LOW |=> generalPinOe[2] && !generalPinOut[2])
    else $error("Pin 2 not driven low");

  chk_status_drive: assert property (@(posedge core_clk) disable iff (rst)
    strapValid && pin3ConfigField == `PIN_CFG_OUT_STATUS |=> generalPinOut[3] == factoryTest)
    else $error("Pin 3 does not show test mode");

  chk_mode_off: assert property (@(posedge core_clk) disable iff (rst)
    referencePinMode inside {`REF_MODE_RESET, 2'h3} |=> !crystalDriverEn && !externalClockEn)
    else $error("Reference driver on in unused mode");

  // Set must win even while the clear is held
  chk_latch_set: assert property (@(posedge core_clk) disable iff (rst)
    strapValid |=> (pinStatusReg[7:4] & $past(syncPins[3:0])) == $past(syncPins[3:0]))
    else $error("High pin not latched");

  chk_latch_sticky: assert property (@(posedge core_clk) disable iff (rst)
    strapValid && !statusLatchClear |=>
      (pinStatusReg[7:4] & $past(pinStatusReg[7:4])) == $past(pinStatusReg[7:4]))
    else $error("Latched bit lost without clear");

  chk_reset_outputs: assert property (@(posedge core_clk)
    rst |-> outputClockEn == 10'h000 && pinStatusReg == 8'h00 &&
            !crystalDriverEn && !externalClockEn)
    else $error("Outputs not cleared in reset");

  cov_test_mode:  cover property (@(posedge core_clk) disable iff (rst)
    $rose(strapValid) && factoryTest);
  cov_cfg_seven:  cover property (@(posedge core_clk) disable iff (rst)
    $rose(strapValid) && configSelect == 3'h7);
  cov_latch_clr:  cover property (@(posedge core_clk) disable iff (rst)
    statusLatchClear && strapValid);
  cov_status_pin: cover property (@(posedge core_clk) disable iff (rst)
    generalPinOe[3] && generalPinOut[3] && factoryTest);
endmodule
`default_nettype wire

// >>> board_strap_model.sv
`default_nettype none
module board_strap_model (
  input  wire logic [3:0] strapLevel,
  input  wire logic [3:0] pinOut,
  input  wire logic [3:0] pinOe,
  output logic      [3:0] padLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  // Strap resistors set the level whenever the device lets the pad go
  // Bench releases reset with the test strap low except in one deliberate run
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      padLevel[i] = pinOe[i] ? pinOut[i] : strapLevel[i];
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 0;
  logic       rst = 1;
  logic [3:0] strap = 0;
  logic [1:0] ifs = 0, cfg2 = 0, cfg3 = 0, refMode = 0;
  logic [7:0] ctl1 = 0;
  logic       clr = 0;
  logic [9:0] oeReq = 0;
  logic [31:0] seed = 18;
  wire  [3:0] pads, pOut, pOe;
  wire  [2:0] cs;
  wire  [1:0] im;
  wire  [7:0] st;
  wire  [9:0] oce;
  wire        ft, sv, xe, ee;
  int         fails = 0, comparisons = 0, cyc = 0;
  logic [3:0] eOut, eOe;
  logic [1:0] pinCfgSet [4];
  logic [5:0] strapQ[$];
  logic [5:0] expStrap;
  logic       expTest = 0;
  board_strap_model u_board (.strapLevel(strap), .pinOut(pOut), .pinOe(pOe), .padLevel(pads));
  reset_strap_and_gpio_mux #(.SIX_OUTPUT(1'b1)) u_dut (.core_clk(core_clk), .rst(rst),
    .generalPinIn(pads), .generalPinOut(pOut), .generalPinOe(pOe), .interfaceStrapIn(ifs),
    .pinControlRegOne(ctl1), .pin2ConfigField(cfg2), .pin3ConfigField(cfg3),
    .referencePinMode(refMode), .statusLatchClear(clr), .outputEnableReq(oeReq),
    .configSelect(cs), .factoryTest(ft), .interfaceMode(im), .strapValid(sv),
    .pinStatusReg(st), .crystalDriverEn(xe), .externalClockEn(ee), .outputClockEn(oce));
  always #20 core_clk = ~core_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic do_reset(logic [3:0] s, logic [1:0] f);
    strap = s;
    ifs = f;
    rst = 1;
    strapQ.push_back({f, s});
    step(12);
    chk("held outputs", {pOut, pOe, sv, cs, ft, im, xe, ee, oce}, 0);
    chk("held status", st, 0);
    rst = 0;
    step(2);
    chk("early valid", {sv, pOe}, 0);
    step(1);
    expStrap = strapQ.pop_front();
    expTest = expStrap[3];
    chk("valid", sv, 1);
    chk("config", cs, expStrap[2:0]);
    chk("test", ft, expStrap[3]);
    chk("iface", im, expStrap[5:4]);
    strap = ~s;
    ifs = ~f;
    step(6);
    chk("held straps", {cs, ft, im}, {expStrap[2:0], expStrap[3], expStrap[5:4]});
    $display("test reset done");
  endtask
  // Every pin walks through every configuration, each pin offset by one
  task automatic pin_round();
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 4; i++) begin
        pinCfgSet[i] = 2'(c + i);
        eOe[i] = (pinCfgSet[i] != 2'h0);
        eOut[i] = (pinCfgSet[i] == 2'h2) || ((pinCfgSet[i] == 2'h3) && expTest);
      end
      strap = 4'(xs());
      ctl1 = {4'(xs()), pinCfgSet[1], pinCfgSet[0]};
      cfg2 = pinCfgSet[2];
      cfg3 = pinCfgSet[3];
      step(4);
      chk("pin oe", pOe, eOe);
      chk("pin out", pOut & eOe, eOut);
      chk("live", st[3:0], (eOe & eOut) | (~eOe & strap));
    end
    $display("test pins done");
  endtask
  initial begin
    do_reset(4'h5, 2'h2);
    do_reset(4'hA, 2'h1);
    pin_round();
    do_reset({1'b0, 3'(xs())}, 2'(xs()));
    pin_round();
    ctl1 = 0;
    cfg2 = 0;
    cfg3 = 0;
    strap = 0;
    clr = 1;
    step(4);
    clr = 0;
    step(2);
    chk("cleared", st, 0);
    strap = 4'h9;
    clr = 1;
    step(4);
    chk("set beats clear", st, 8'h99);
    clr = 0;
    strap = 4'hF;
    step(4);
    strap = 0;
    step(4);
    chk("latched", st, 8'hF0);
    $display("test status done");
    for (int m = 0; m < 4; m++) begin
      refMode = 2'(m);
      oeReq = 10'(xs());
      step(2);
      chk("crystal", xe, m == 1);
      chk("extclk", ee, m == 2);
      // Outputs 2, 5, 7 and 10 are absent on the six-output part
      chk("outputs", oce, oeReq & ~10'h252);
    end
    $display("test modes done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
